// ===== hw/uab_defines.vh
/*
 Register map, field positions, reset values and counts for the asynchronous serial port.
 Assumes inclusion by its bare name from the design files; definitions only.
*/
`ifndef UAB_DEFINES_VH
`define UAB_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define UAB_IDX_SERIAL_CONTROL      10'h098
`define UAB_IDX_SERIAL_DATA_BUFFER  10'h099
`define UAB_IDX_RATE_CONTROL        10'h09a
`define UAB_IDX_TIMER2_RELOAD       10'h09b
`define UAB_IDX_FRACTIONAL_RATIO    10'h09d
`define UAB_IDX_BAUD_TIMER_CONTROL  10'h09e

// Byte addresses on the register bus, one aligned word each.
`define UAB_OFF_SERIAL_CONTROL      {`UAB_IDX_SERIAL_CONTROL, 2'b00}
`define UAB_OFF_SERIAL_DATA_BUFFER  {`UAB_IDX_SERIAL_DATA_BUFFER, 2'b00}
`define UAB_OFF_RATE_CONTROL        {`UAB_IDX_RATE_CONTROL, 2'b00}
`define UAB_OFF_TIMER2_RELOAD       {`UAB_IDX_TIMER2_RELOAD, 2'b00}
`define UAB_OFF_FRACTIONAL_RATIO    {`UAB_IDX_FRACTIONAL_RATIO, 2'b00}
`define UAB_OFF_BAUD_TIMER_CONTROL  {`UAB_IDX_BAUD_TIMER_CONTROL, 2'b00}

// Serial control fields.
`define UAB_SC_MODE_HIGH   7
`define UAB_SC_MODE_LOW    6
`define UAB_SC_FILTER      5
`define UAB_SC_RX_ENABLE   4
`define UAB_SC_TX_NINTH    3
`define UAB_SC_RX_NINTH    2
`define UAB_SC_TX_DONE     1
`define UAB_SC_RX_DONE     0

// Rate control fields.
`define UAB_RC_DOUBLER     0
`define UAB_RC_TX_TIMER2   1
`define UAB_RC_RX_TIMER2   2

// Baud timer control and fractional ratio fields.
`define UAB_BT_ENABLE      7
`define UAB_BT_DIV_HI      2
`define UAB_BT_DIV_LO      0
`define UAB_FR_HI          5

// Reset values.
`define UAB_RST_BYTE       8'h00
`define UAB_RST_RELOAD     16'h0000
`define UAB_RST_FRAC       6'h00
`define UAB_RST_DIV        3'h0

// Oversampling, baud timer and framing counts.
`define UAB_OS_LAST        4'hf
`define UAB_OS_MID         4'h7
`define UAB_T2_TOP         16'hffff
`define UAB_FRAC_STEP      15'h0040
`define UAB_BITS_8BIT      4'h9
`define UAB_BITS_9BIT      4'ha
`define UAB_RX_DATA_8BIT   4'h8
`define UAB_RX_DATA_9BIT   4'h9

`endif

// ===== hw/uab_uart.v
/*
 Asynchronous serial port with 8-bit and 9-bit frames, fixed or variable bit rate, a timer 2
 baud counter and a fractional baud timer, reached over an AHB-Lite slave port.
 Assumes one 20 MHz clock, inputs synchronous to it, and timer 1 overflow given as a pulse.
*/
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "uab_defines.vh"

module uab_uart (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire        timer1_overflow,
   input  wire        rxd,
   output reg         txd
);

   localparam RX_IDLE  = 2'b00;
   localparam RX_START = 2'b01;
   localparam RX_DATA  = 2'b10;

   function [3:0] uab_rx_bits;
      input nine;
      begin
         uab_rx_bits = nine ? `UAB_RX_DATA_9BIT : `UAB_RX_DATA_8BIT;
      end
   endfunction

   reg        mode_select_high_reg;
   reg        mode_select_low_reg;
   reg        multiproc_filter_enable_reg;
   reg        rx_enable_reg;
   reg        tx_ninth_bit_reg;
   reg        rx_ninth_bit_reg;
   reg        tx_done_flag_reg;
   reg        rx_done_flag_reg;
   reg        baud_doubler_reg;
   reg        tx_clock_from_timer2_reg;
   reg        rx_clock_from_timer2_reg;
   reg [15:0] timer2_reload_reg;
   reg [5:0]  fractional_ratio_reg;
   reg        baud_timer_select_reg;
   reg [2:0]  baud_div_reg;
   reg [7:0]  rx_buffer_reg;

   reg        wr_pend_reg;
   reg [11:0] waddr_reg;
   reg [31:0] rdata_next;

   reg [15:0] t2_count_reg;
   reg        t2_phase_reg;
   reg        t1_phase_reg;
   reg        fixed_phase_reg;
   reg [14:0] frac_acc_reg;

   reg [3:0]  tx_os_reg;
   reg [9:0]  tx_shift_reg;
   reg [3:0]  tx_count_reg;
   reg        tx_pend_reg;
   reg        tx_busy_reg;

   reg [1:0]  rx_state_reg;
   reg [3:0]  rx_os_reg;
   reg [3:0]  rx_count_reg;
   reg [8:0]  rx_shift_reg;
   reg        rxd_prev_reg;

   wire take     = hsel & hready & htrans[1];
   wire wr_ctrl  = wr_pend_reg & (waddr_reg == `UAB_OFF_SERIAL_CONTROL);
   wire wr_data  = wr_pend_reg & (waddr_reg == `UAB_OFF_SERIAL_DATA_BUFFER);
   wire wr_rate  = wr_pend_reg & (waddr_reg == `UAB_OFF_RATE_CONTROL);
   wire wr_rld   = wr_pend_reg & (waddr_reg == `UAB_OFF_TIMER2_RELOAD);
   wire wr_frac  = wr_pend_reg & (waddr_reg == `UAB_OFF_FRACTIONAL_RATIO);
   wire wr_bt    = wr_pend_reg & (waddr_reg == `UAB_OFF_BAUD_TIMER_CONTROL);

   wire nine     = mode_select_high_reg;
   wire var_rate = mode_select_low_reg;
   wire active   = mode_select_high_reg | mode_select_low_reg;
   // A write that selects the inactive mode drops the transmit frame in the cycle it lands.
   wire going_idle = ~active |
                     (wr_ctrl & ~hwdata[`UAB_SC_MODE_HIGH] & ~hwdata[`UAB_SC_MODE_LOW]);
   wire bt_on    = baud_timer_select_reg & var_rate;

   // Baud source ticks at sixteen times the bit rate.
   wire t2_run   = ~bt_on & (tx_clock_from_timer2_reg | rx_clock_from_timer2_reg);
   wire t2_ovf   = t2_run & t2_phase_reg & (t2_count_reg == `UAB_T2_TOP);
   // Without the doubler only every second timer 1 overflow counts.
   wire t1_tick  = timer1_overflow & (baud_doubler_reg | t1_phase_reg);
   wire fix_tick = baud_doubler_reg | fixed_phase_reg;
   // The accumulator gains 64 per clock and ticks each time it passes the scaled divider.
   wire [13:0] frac_div = {7'h00, 1'b1, fractional_ratio_reg} << baud_div_reg;
   wire [14:0] frac_sum = frac_acc_reg + `UAB_FRAC_STEP;
   wire bt_tick  = frac_sum >= {1'b0, frac_div};

   wire tx_os_tick = ~var_rate ? fix_tick :
                     bt_on ? bt_tick :
                     tx_clock_from_timer2_reg ? t2_ovf : t1_tick;
   wire rx_os_tick = ~var_rate ? fix_tick :
                     bt_on ? bt_tick :
                     rx_clock_from_timer2_reg ? t2_ovf : t1_tick;
   // The oversample count runs freely, so a send waits for the next bit boundary.
   wire tx_bit_tick = tx_os_tick & (tx_os_reg == `UAB_OS_LAST);
   // The stop sample decides whether the frame is kept or lost.

   wire rx_stop_now = (rx_state_reg == RX_DATA) & rx_os_tick &
                      (rx_os_reg == `UAB_OS_LAST) & (rx_count_reg == uab_rx_bits(nine));
   wire rx_keep     = ~rx_done_flag_reg & rxd &
                      ~(nine & multiproc_filter_enable_reg & ~rx_shift_reg[8]);
   wire rx_set      = rx_stop_now & rx_keep;
   wire tx_set      = tx_bit_tick & tx_busy_reg & (tx_count_reg == 4'h1);

   // Every access completes without wait states and always answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always @* begin
      rdata_next = 32'h0000_0000;
      case (haddr[11:0])
         `UAB_OFF_SERIAL_CONTROL:
            rdata_next[7:0] = {mode_select_high_reg, mode_select_low_reg,
                               multiproc_filter_enable_reg, rx_enable_reg, tx_ninth_bit_reg,
                               rx_ninth_bit_reg, tx_done_flag_reg, rx_done_flag_reg};
         `UAB_OFF_SERIAL_DATA_BUFFER:
            rdata_next[7:0] = rx_buffer_reg;
         `UAB_OFF_RATE_CONTROL:
            rdata_next[2:0] = {rx_clock_from_timer2_reg, tx_clock_from_timer2_reg,
                               baud_doubler_reg};
         `UAB_OFF_TIMER2_RELOAD:
            rdata_next[15:0] = timer2_reload_reg;
         `UAB_OFF_FRACTIONAL_RATIO:
            rdata_next[`UAB_FR_HI:0] = fractional_ratio_reg;
         `UAB_OFF_BAUD_TIMER_CONTROL: begin
            rdata_next[`UAB_BT_ENABLE] = baud_timer_select_reg;
            rdata_next[`UAB_BT_DIV_HI:`UAB_BT_DIV_LO] = baud_div_reg;
         end
         default:
            rdata_next = 32'h0000_0000;
      endcase
   end

   // Bus slave: write data is taken in the data phase, read data is registered.
   // Read data is captured in the address phase, so a read pipelined straight behind a
   // write to the same register returns the value from before that write.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         waddr_reg   <= 12'h000;
         hrdata      <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= take & hwrite;
         if (take) begin
            waddr_reg <= haddr[11:0];
         end
         if (take & ~hwrite) begin
            hrdata <= rdata_next;
         end
      end
   end

   // Configuration registers and flags; a hardware set wins over a software write.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_select_high_reg        <= 1'b0;
         mode_select_low_reg         <= 1'b0;
         multiproc_filter_enable_reg <= 1'b0;
         rx_enable_reg               <= 1'b0;
         tx_ninth_bit_reg            <= 1'b0;
         rx_ninth_bit_reg            <= 1'b0;
         tx_done_flag_reg            <= 1'b0;
         rx_done_flag_reg            <= 1'b0;
         baud_doubler_reg            <= 1'b0;
         tx_clock_from_timer2_reg    <= 1'b0;
         rx_clock_from_timer2_reg    <= 1'b0;
         timer2_reload_reg           <= `UAB_RST_RELOAD;
         fractional_ratio_reg        <= `UAB_RST_FRAC;
         baud_timer_select_reg       <= 1'b0;
         baud_div_reg                <= `UAB_RST_DIV;
         rx_buffer_reg               <= `UAB_RST_BYTE;
      end else begin
         if (wr_ctrl) begin
            mode_select_high_reg        <= hwdata[`UAB_SC_MODE_HIGH];
            mode_select_low_reg         <= hwdata[`UAB_SC_MODE_LOW];
            multiproc_filter_enable_reg <= hwdata[`UAB_SC_FILTER];
            rx_enable_reg               <= hwdata[`UAB_SC_RX_ENABLE];
            tx_ninth_bit_reg            <= hwdata[`UAB_SC_TX_NINTH];
         end
         if (tx_set) begin
            tx_done_flag_reg <= 1'b1;
         end else if (wr_ctrl) begin
            tx_done_flag_reg <= hwdata[`UAB_SC_TX_DONE];
         end
         if (rx_set) begin
            rx_done_flag_reg <= 1'b1;
            rx_ninth_bit_reg <= nine ? rx_shift_reg[8] : rxd;
            rx_buffer_reg    <= nine ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
         end else if (wr_ctrl) begin
            rx_done_flag_reg <= hwdata[`UAB_SC_RX_DONE];
            rx_ninth_bit_reg <= hwdata[`UAB_SC_RX_NINTH];
         end
         if (wr_rate) begin
            baud_doubler_reg         <= hwdata[`UAB_RC_DOUBLER];
            tx_clock_from_timer2_reg <= hwdata[`UAB_RC_TX_TIMER2];
            rx_clock_from_timer2_reg <= hwdata[`UAB_RC_RX_TIMER2];
         end
         if (wr_rld) begin
            timer2_reload_reg <= hwdata[15:0];
         end
         if (wr_frac) begin
            fractional_ratio_reg <= hwdata[`UAB_FR_HI:0];
         end
         if (wr_bt) begin
            baud_timer_select_reg <= hwdata[`UAB_BT_ENABLE];
            baud_div_reg          <= hwdata[`UAB_BT_DIV_HI:`UAB_BT_DIV_LO];
         end
      end
   end

   // Baud sources: timer 2 baud counter, timer 1 halving, fixed rate and fractional timer.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t2_count_reg    <= `UAB_RST_RELOAD;
         t2_phase_reg    <= 1'b0;
         t1_phase_reg    <= 1'b0;
         fixed_phase_reg <= 1'b0;
         frac_acc_reg    <= 15'h0000;
      end else begin
         fixed_phase_reg <= ~fixed_phase_reg;
         if (timer1_overflow) begin
            t1_phase_reg <= ~t1_phase_reg;
         end
         if (t2_run) begin
            t2_phase_reg <= ~t2_phase_reg;
            if (t2_phase_reg) begin
               if (t2_count_reg == `UAB_T2_TOP) begin
                  t2_count_reg <= timer2_reload_reg;
               end else begin
                  t2_count_reg <= t2_count_reg + 16'h0001;
               end
            end
         end else begin
            t2_phase_reg <= 1'b0;
            t2_count_reg <= timer2_reload_reg;
         end
         if (bt_on) begin
            frac_acc_reg <= bt_tick ? frac_sum - {1'b0, frac_div} : frac_sum;
         end else begin
            frac_acc_reg <= 15'h0000;
         end
      end
   end

   // Transmitter.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_os_reg    <= 4'h0;
         tx_shift_reg <= 10'h3ff;
         tx_count_reg <= 4'h0;
         tx_pend_reg  <= 1'b0;
         tx_busy_reg  <= 1'b0;
         txd          <= 1'b1;
      end else begin
         if (tx_os_tick) begin
            tx_os_reg <= tx_os_reg + 4'h1;
         end
         if (wr_data & active) begin
            tx_shift_reg <= {1'b1, nine ? tx_ninth_bit_reg : 1'b1, hwdata[7:0]};
            tx_pend_reg  <= 1'b1;
            tx_busy_reg  <= 1'b0;
            txd          <= 1'b1;
         end else if (going_idle) begin
            tx_pend_reg <= 1'b0;
            tx_busy_reg <= 1'b0;
            txd         <= 1'b1;
         end else if (tx_bit_tick) begin
            if (tx_pend_reg) begin
               txd          <= 1'b0;
               tx_pend_reg  <= 1'b0;
               tx_busy_reg  <= 1'b1;
               tx_count_reg <= nine ? `UAB_BITS_9BIT : `UAB_BITS_8BIT;
            end else if (tx_busy_reg) begin
               if (tx_count_reg == 4'h0) begin
                  tx_busy_reg <= 1'b0;
                  txd         <= 1'b1;
               end else begin
                  txd          <= tx_shift_reg[0];
                  tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                  tx_count_reg <= tx_count_reg - 4'h1;
               end
            end
         end
      end
   end

   // Receiver, sampling sixteen times per bit.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_state_reg <= RX_IDLE;
         rx_os_reg    <= 4'h0;
         rx_count_reg <= 4'h0;
         rx_shift_reg <= 9'h000;
         rxd_prev_reg <= 1'b1;
      end else if (rx_os_tick) begin
         rxd_prev_reg <= rxd;
         case (rx_state_reg)
            RX_IDLE: begin
               rx_os_reg    <= 4'h0;
               rx_count_reg <= 4'h0;
               if (active & rx_enable_reg & rxd_prev_reg & ~rxd) begin
                  rx_state_reg <= RX_START;
               end
            end
            RX_START: begin
               rx_os_reg <= rx_os_reg + 4'h1;
               if (rx_os_reg == `UAB_OS_MID - 4'h1) begin
                  rx_os_reg    <= 4'h0;
                  rx_state_reg <= rxd ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               rx_os_reg <= rx_os_reg + 4'h1;
               if (rx_os_reg == `UAB_OS_LAST) begin
                  if (rx_count_reg == uab_rx_bits(nine)) begin
                     rx_state_reg <= RX_IDLE;
                  end else begin
                     rx_shift_reg <= {rxd, rx_shift_reg[8:1]};
                     rx_count_reg <= rx_count_reg + 4'h1;
                  end
               end
            end
            default: begin
               rx_state_reg <= RX_IDLE;
            end
         endcase
      end
   end

endmodule // uab_uart
`default_nettype wire

// ===== test/uab_uart_chk.sv
/*
 Concurrent checks on the serial port, bound to its top module.
 Assumes zero-wait single word transfers and the map in uab_defines.vh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uab_defines.vh"
module uab_uart_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        txd
);
   localparam logic [11:0] o_sc = `UAB_OFF_SERIAL_CONTROL;
   localparam logic [11:0] o_db = `UAB_OFF_SERIAL_DATA_BUFFER;
   localparam logic [11:0] o_fr = `UAB_OFF_FRACTIONAL_RATIO;
   localparam logic [11:0] o_bt = `UAB_OFF_BAUD_TIMER_CONTROL;
   logic        dw;
   logic        dr;
   logic [11:0] da;
   logic [7:0]  cm;
   logic [7:0]  bm;
   logic [5:0]  fm;
   wire         ap = hsel & hready & htrans[1];
   wire         known = da[11:4] == 8'h26 || da == o_fr || da == o_bt;

   // Shadows of the serial control, baud timer control and fractional ratio fields, updated in each write data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dw <= 1'b0;
         dr <= 1'b0;
         da <= 12'h0;
         cm <= 8'h0;
         bm <= 8'h0;
         fm <= 6'h0;
      end else begin
         dw <= ap & hwrite;
         dr <= ap & !hwrite;
         if (ap) da <= haddr[11:0];
         if (dw && da == o_sc) cm <= hwdata[7:0];
         if (dw && da == o_bt) bm <= hwdata[7:0];
         if (dw && da == o_fr) fm <= hwdata[5:0];
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   chk_rdata_holds: assert property (!(ap && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   chk_unmapped_zero: assert property (dr && !known |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_frac_width: assert property (dr && da == o_fr |-> hrdata == {26'h0, fm})
      else $error("fractional ratio readback wrong");
   chk_mode_readback: assert property (dr && da == o_sc |-> hrdata[7:3] == cm[7:3])
      else $error("serial control readback wrong");
   chk_timer_sel: assert property (dr && da == o_bt |->
      hrdata[7] == bm[7] && hrdata[2:0] == bm[2:0])
      else $error("baud timer control readback wrong");
   chk_idle_mode: assert property (cm[7:6] == 2'b00 |-> txd)
      else $error("line active in inactive mode");
   chk_fixed_start: assert property (dw && da == o_db && cm[7:6] == 2'b10 |-> ##[1:40] !txd)
      else $error("fixed rate start bit late");
   chk_bit_hold: assert property ($changed(txd) |=> $stable(txd) [*8])
      else $error("serial bit too short");

   cover property (dw && da == o_db && cm[7:6] == 2'b10);
   cover property (dr && da == o_fr);
   cover property ($fell(txd));
endmodule // uab_uart_chk

bind uab_uart uab_uart_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hreadyout, .hresp, .hrdata, .txd);
`default_nettype wire

// ===== test/uab_far.sv
/*
 Remote serial station: captures frames seen on txd and sends frames on rxd.
 Assumes the bench sets the observed bit length in clocks and the nine-bit framing.
*/
`timescale 1ns/1ps
`default_nettype none
module uab_far (
   input  wire logic        hclk,
   input  wire logic        txd,
   input  wire logic [15:0] obs,
   input  wire logic        nine,
   output logic             rxd,
   output logic [10:0]      fr,
   output int               n_got
);
   logic [10:0] sh;
   initial begin
      rxd = 1'b1;
      fr = 11'h0;
      n_got = 0;
   end

   // Samples each bit at its middle; fr is {stop, ninth, data, start}.
   always begin
      @(negedge txd);
      for (int i = 0; i < 10 + nine; i++) begin
         repeat (i == 0 ? obs / 2 : obs) @(posedge hclk);
         sh[i] = txd;
      end
      fr = nine ? sh : {sh[9], 1'b0, sh[8:0]};
      n_got++;
   end

   task automatic send(input int c, input logic [8:0] d, input logic s);
      logic [10:0] f;
      f = nine ? {s, d, 1'b0} : {1'b1, s, d[7:0], 1'b0};
      for (int i = 0; i < 10 + nine; i++) begin
         rxd <= f[i];
         repeat (c) @(posedge hclk);
      end
      rxd <= 1'b1;
   endtask

   // A low glitch far shorter than half a bit.
   task automatic pulse(input int n);
      rxd <= 1'b0;
      repeat (n) @(posedge hclk);
      rxd <= 1'b1;
      repeat (40) @(posedge hclk);
   endtask
endmodule // uab_far
`default_nettype wire

// ===== test/tb.sv
/*
 Self-checking bench for the serial port: bus tasks, a remote station, frame checks.
 Assumes the checker binds itself and uab_defines.vh is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uab_defines.vh"
module tb;
   localparam logic [11:0] a_sc = `UAB_OFF_SERIAL_CONTROL;
   localparam logic [11:0] a_db = `UAB_OFF_SERIAL_DATA_BUFFER;
   localparam logic [11:0] a_rc = `UAB_OFF_RATE_CONTROL;
   localparam logic [11:0] a_t2 = `UAB_OFF_TIMER2_RELOAD;
   localparam logic [11:0] a_fr = `UAB_OFF_FRACTIONAL_RATIO;
   localparam logic [11:0] a_bt = `UAB_OFF_BAUD_TIMER_CONTROL;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        t1_ovf = 1'b0;
   logic        nine = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [15:0] obs = 16'd16;
   wire         hready;
   wire         hresp;
   wire         txd;
   wire         rxd;
   wire  [31:0] hrdata;
   wire  [10:0] fr;
   int          n_got;
   int          seen = 0;
   int          cyc = 0;
   int          n_fail = 0;
   int          samples_checked = 0;

   uab_uart u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hreadyout(hready), .hresp, .hrdata, .timer1_overflow(t1_ovf), .rxd, .txd);
   uab_far u_far (.hclk, .txd, .obs, .nine, .rxd, .fr, .n_got);

   always #25 hclk = ~hclk;

   // Timer 1 overflows every other clock; no timer 1 interrupt exists here to disable.
   always @(posedge hclk) begin
      t1_ovf <= ~t1_ovf;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Waits for hready high at a rising edge; an answer that never comes counts as a mismatch.
   task automatic wait_ready();
      int t;
      t = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && t < 50) begin
         @(posedge hclk);
         t++;
      end
      if (hready !== 1'b1) n_fail++;
   endtask

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= w ? d : 32'h0;
      wait_ready();
      q = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   // Waits for the next captured frame, lets its stop bit end, then compares it.
   task automatic frame(input logic d9, input logic [7:0] d);
      int t;
      t = 0;
      while (n_got == seen && t < 3000) begin
         @(posedge hclk);
         t++;
      end
      if (n_got == seen) n_fail++;
      seen = n_got;
      repeat (obs) @(posedge hclk);
      chk({21'h0, fr}, {21'h0, 1'b1, d9, d, 1'b0});
   endtask

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk(a_sc, 32'h0);
      rchk(a_bt, 32'h0);
      wr(a_fr, 32'hff);
      rchk(a_fr, 32'h3f);
      rchk(12'h270, 32'h0);
      wr(a_t2, 32'hffff);
      wr(a_fr, 32'h0);
      wr(a_db, 32'h55);
      $display("test registers done");
      wr(a_bt, 32'h80);
      rchk(a_bt, 32'h80);
      wr(a_rc, 32'h3);
      wr(a_sc, 32'h40);
      u_far.send(16, 9'h055, 1'b1);
      rchk(a_sc, 32'h40);
      wr(a_sc, 32'h50);
      u_far.pulse(4);
      rchk(a_sc, 32'h50);
      wr(a_db, 32'ha5);
      frame(1'b0, 8'ha5);
      rchk(a_sc, 32'h52);
      u_far.send(16, 9'h03c, 1'b1);
      rchk(a_sc, 32'h57);
      rchk(a_db, 32'h3c);
      u_far.send(16, 9'h011, 1'b1);
      rchk(a_db, 32'h3c);
      wr(a_sc, 32'h50);
      u_far.send(16, 9'h022, 1'b0);
      rchk(a_sc, 32'h50);
      $display("test eight bit done");
      wr(a_bt, 32'h81);
      obs <= 16'd32;
      nine <= 1'b1;
      wr(a_sc, 32'hd8);
      wr(a_db, 32'h96);
      frame(1'b1, 8'h96);
      rchk(a_sc, 32'hda);
      wr(a_sc, 32'hf0);
      u_far.send(32, 9'h0a5, 1'b1);
      rchk(a_sc, 32'hf0);
      u_far.send(32, 9'h15a, 1'b1);
      rchk(a_sc, 32'hf5);
      rchk(a_db, 32'h5a);
      $display("test nine bit done");
      wr(a_bt, 32'h0);
      wr(a_rc, 32'h1);
      obs <= 16'd16;
      wr(a_sc, 32'h80);
      wr(a_db, 32'h0f);
      frame(1'b0, 8'h0f);
      wr(a_rc, 32'h0);
      obs <= 16'd32;
      wr(a_sc, 32'h88);
      wr(a_db, 32'hf0);
      frame(1'b1, 8'hf0);
      $display("test fixed rate done");
      nine <= 1'b0;
      wr(a_sc, 32'h50);
      wr(a_rc, 32'h1);
      wr(a_db, 32'h81);
      frame(1'b0, 8'h81);
      wr(a_rc, 32'h0);
      obs <= 16'd64;
      wr(a_db, 32'h7e);
      frame(1'b0, 8'h7e);
      wr(a_rc, 32'h2);
      obs <= 16'd32;
      wr(a_db, 32'h3c);
      frame(1'b0, 8'h3c);
      u_far.send(64, 9'h0c3, 1'b1);
      rchk(a_db, 32'hc3);
      $display("test timer rates done");
      test_done();
   end
endmodule // tb
`default_nettype wire
